/* logic/ddu_top.sv */
// Dual converter update control: register decode, update queue and latches
`default_nettype none

module ddu_top (
    input  wire logic             clk_sys_i,   // System clock, 100 MHz
    input  wire logic             resetn_i,    // Synchronous reset, active low
    input  wire logic [7:0]       sfr_addr_i,  // Register address
    input  wire logic [7:0]       sfr_page_i,  // Register page
    input  wire logic             sfr_wr_i,    // Write strobe
    input  wire logic [7:0]       sfr_wdata_i, // Write data
    output logic      [7:0]       sfr_rdata_o, // Read data, one cycle later
    input  wire logic             tmr2_ovf_i,  // Timer 2 overflow pulse
    input  wire logic             tmr3_ovf_i,  // Timer 3 overflow pulse
    input  wire logic             tmr4_ovf_i,  // Timer 4 overflow pulse
    input  wire logic             conv_ready_i, // Converter latch accepts
    output ddu_pkg::ddu_out_type  conv0_o,     // Channel 0 latch and pin
    output ddu_pkg::ddu_out_type  conv1_o      // Channel 1 latch and pin
);
    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    logic                  wr_low0;
    logic                  wr_high0;
    logic                  wr_ctrl0;
    logic                  wr_low1;
    logic                  wr_high1;
    logic                  wr_ctrl1;
    logic [2:0]            tmr_ovf;
    ddu_pkg::ddu_ctrl_type ctrl0;
    ddu_pkg::ddu_ctrl_type ctrl1;
    logic [7:0]            low0;
    logic [7:0]            high0;
    logic [7:0]            low1;
    logic [7:0]            high1;
    logic                  req0;
    logic                  req1;
    logic [11:0]           word0;
    logic [11:0]           word1;
    logic                  take0;
    logic                  take1;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    ddu_pkg::ddu_upd_type  fifo_in;
    ddu_pkg::ddu_upd_type  fifo_out;
    logic                  pop;
    logic [7:0]            rdata_nxt;
    ddu_pkg::ddu_out_type  out0_r;
    ddu_pkg::ddu_out_type  out1_r;
    logic [7:0]            rdata_r;

    assign wr_low0  = sfr_wr_i &&
                      ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i,
                                       ddu_pkg::ADDR_DATA_LOW, ddu_pkg::PAGE_CH0);
    assign wr_high0 = sfr_wr_i &&
                      ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i,
                                       ddu_pkg::ADDR_DATA_HIGH, ddu_pkg::PAGE_CH0);
    assign wr_ctrl0 = sfr_wr_i &&
                      ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i,
                                       ddu_pkg::ADDR_CTRL, ddu_pkg::PAGE_CH0);
    assign wr_low1  = sfr_wr_i &&
                      ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i,
                                       ddu_pkg::ADDR_DATA_LOW, ddu_pkg::PAGE_CH1);
    assign wr_high1 = sfr_wr_i &&
                      ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i,
                                       ddu_pkg::ADDR_DATA_HIGH, ddu_pkg::PAGE_CH1);
    assign wr_ctrl1 = sfr_wr_i &&
                      ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i,
                                       ddu_pkg::ADDR_CTRL, ddu_pkg::PAGE_CH1);

    assign tmr_ovf = {tmr4_ovf_i, tmr3_ovf_i, tmr2_ovf_i};

    // ------------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------------
    ddu_chan u_chan0 (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_low_i  (wr_low0),
        .wr_high_i (wr_high0),
        .wr_ctrl_i (wr_ctrl0),
        .wdata_i   (sfr_wdata_i),
        .ovf_i     (tmr_ovf),
        .take_i    (take0),
        .ctrl_o    (ctrl0),
        .low_o     (low0),
        .high_o    (high0),
        .req_o     (req0),
        .word_o    (word0)
    );

    ddu_chan u_chan1 (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_low_i  (wr_low1),
        .wr_high_i (wr_high1),
        .wr_ctrl_i (wr_ctrl1),
        .wdata_i   (sfr_wdata_i),
        .ovf_i     (tmr_ovf),
        .take_i    (take1),
        .ctrl_o    (ctrl1),
        .low_o     (low1),
        .high_o    (high1),
        .req_o     (req1),
        .word_o    (word1)
    );

    // ------------------------------------------------------------------------
    // Update queue; channel 0 first, a full queue keeps words pending
    // ------------------------------------------------------------------------
    assign take0        = req0 && fifo_in_ready;
    assign take1        = req1 && !req0 && fifo_in_ready;
    assign fifo_in.chan = !req0;
    assign fifo_in.word = req0 ? word0 : word1;
    assign pop          = fifo_out_valid && conv_ready_i;

    ddu_fifo #(
        .WIDTH ($bits(ddu_pkg::ddu_upd_type)),
        .DEPTH (ddu_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (req0 || req1),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (conv_ready_i),
        .out_data_o  (fifo_out)
    );

    // ------------------------------------------------------------------------
    // Converter latches and output pin state
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            out0_r <= '0;
        end else begin
            out0_r.drive    <= ctrl0.enable;
            out0_r.shutdown <= !ctrl0.enable;
            if (pop && !fifo_out.chan) begin
                out0_r.word <= fifo_out.word;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            out1_r <= '0;
        end else begin
            out1_r.drive    <= ctrl1.enable;
            out1_r.shutdown <= !ctrl1.enable;
            if (pop && fifo_out.chan) begin
                out1_r.word <= fifo_out.word;
            end
        end
    end

    assign conv0_o = out0_r;
    assign conv1_o = out1_r;

    // ------------------------------------------------------------------------
    // Read mux, unmapped reads return zero
    // ------------------------------------------------------------------------
    always_comb begin
        rdata_nxt = ddu_pkg::RDATA_UNMAPPED;
        if (ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i, ddu_pkg::ADDR_DATA_LOW,
                             ddu_pkg::PAGE_CH0)) begin
            rdata_nxt = low0;
        end else if (ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i, ddu_pkg::ADDR_DATA_HIGH,
                                      ddu_pkg::PAGE_CH0)) begin
            rdata_nxt = high0;
        end else if (ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i, ddu_pkg::ADDR_CTRL,
                                      ddu_pkg::PAGE_CH0)) begin
            rdata_nxt = ctrl0;
        end else if (ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i, ddu_pkg::ADDR_DATA_LOW,
                                      ddu_pkg::PAGE_CH1)) begin
            rdata_nxt = low1;
        end else if (ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i, ddu_pkg::ADDR_DATA_HIGH,
                                      ddu_pkg::PAGE_CH1)) begin
            rdata_nxt = high1;
        end else if (ddu_pkg::sfr_hit(sfr_addr_i, sfr_page_i, ddu_pkg::ADDR_CTRL,
                                      ddu_pkg::PAGE_CH1)) begin
            rdata_nxt = ctrl1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rdata_r <= ddu_pkg::RDATA_UNMAPPED;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign sfr_rdata_o = rdata_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking

    default disable iff (!resetn_i);

    property p_off;
        !ctrl0.enable |=> conv0_o.shutdown && !conv0_o.drive;
    endproperty
    a_off: assert property (p_off)
        else $error("disabled channel not in shutdown");

    property p_on;
        ctrl1.enable |=> conv1_o.drive && !conv1_o.shutdown;
    endproperty
    a_on: assert property (p_on)
        else $error("enabled channel not driving");

    property p_on0;
        ctrl0.enable |=> conv0_o.drive && !conv0_o.shutdown;
    endproperty
    a_on0: assert property (p_on0)
        else $error("enabled channel 0 not driving");

    property p_off1;
        !ctrl1.enable |=> conv1_o.shutdown && !conv1_o.drive;
    endproperty
    a_off1: assert property (p_off1)
        else $error("disabled channel 1 not in shutdown");

    property p_wr_trig;
        wr_high0 && ctrl0.mode == ddu_pkg::MODE_WRITE |=> req0;
    endproperty
    a_wr_trig: assert property (p_wr_trig)
        else $error("high byte write gave no update");

    property p_t3;
        ctrl0.mode == ddu_pkg::MODE_T3 && tmr3_ovf_i && !wr_ctrl0 |=> req0;
    endproperty
    a_t3: assert property (p_t3)
        else $error("timer 3 overflow gave no update");

    property p_t2;
        ctrl1.mode == ddu_pkg::MODE_T2 && tmr2_ovf_i && !wr_ctrl1 |=> req1;
    endproperty
    a_t2: assert property (p_t2)
        else $error("timer 2 overflow gave no update");

    property p_t4;
        ctrl0.mode == ddu_pkg::MODE_T4 && tmr4_ovf_i && !wr_ctrl0 |=> req0;
    endproperty
    a_t4: assert property (p_t4)
        else $error("timer 4 overflow gave no update");

    property p_wr_no_tmr;
        ctrl1.mode == ddu_pkg::MODE_WRITE && |tmr_ovf && !wr_high1 && !req1 |=> !req1;
    endproperty
    a_wr_no_tmr: assert property (p_wr_no_tmr)
        else $error("overflow updated write-triggered channel");

    property p_rsv;
        wr_ctrl0 |=> ctrl0.rsv == 2'h0 && ctrl0.mode == $past(sfr_wdata_i[4:3]);
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("control fields misplaced");

    property p_just0;
        wr_high0 && ctrl0.mode == ddu_pkg::MODE_WRITE && ctrl0.justify == 3'h0
        |=> word0 == {$past(sfr_wdata_i[3:0]), $past(low0)};
    endproperty
    a_just0: assert property (p_just0)
        else $error("justify 000 word wrong");

    property p_just1;
        wr_high0 && ctrl0.mode == ddu_pkg::MODE_WRITE && ctrl0.justify == 3'h1
        |=> word0 == {$past(sfr_wdata_i[4:0]), $past(low0[7:1])};
    endproperty
    a_just1: assert property (p_just1)
        else $error("justify 001 word wrong");

    property p_just2;
        wr_high0 && ctrl0.mode == ddu_pkg::MODE_WRITE && ctrl0.justify == 3'h2
        |=> word0 == {$past(sfr_wdata_i[5:0]), $past(low0[7:2])};
    endproperty
    a_just2: assert property (p_just2)
        else $error("justify 010 word wrong");

    property p_just3;
        wr_high0 && ctrl0.mode == ddu_pkg::MODE_WRITE && ctrl0.justify == 3'h3
        |=> word0 == {$past(sfr_wdata_i[6:0]), $past(low0[7:3])};
    endproperty
    a_just3: assert property (p_just3)
        else $error("justify 011 word wrong");

    property p_just4;
        wr_high0 && ctrl0.mode == ddu_pkg::MODE_WRITE && ctrl0.justify[2]
        |=> word0 == {$past(sfr_wdata_i), $past(low0[7:4])};
    endproperty
    a_just4: assert property (p_just4)
        else $error("justify 1xx word wrong");

    property p_addr;
        wr_high0 |=> high0 == $past(sfr_wdata_i) ##1 sfr_rdata_o == $past(high0);
    endproperty
    a_addr: assert property (p_addr)
        else $error("high byte not at its address");

    property p_page;
        wr_ctrl1 |=> ctrl1 == ($past(sfr_wdata_i) & ddu_pkg::CTRL_WMASK) && $stable(ctrl0);
    endproperty
    a_page: assert property (p_page)
        else $error("page 1 control write misrouted");

    property p_low_hold;
        wr_low0 && ctrl0.mode == ddu_pkg::MODE_WRITE && !req0 |=> !req0;
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low byte write updated output");

    property p_tmr_hold;
        (wr_low0 || wr_high0) && ctrl0.mode != ddu_pkg::MODE_WRITE && !req0
        && !ddu_pkg::ovf_sel(ctrl0.mode, tmr_ovf) |=> !req0;
    endproperty
    a_tmr_hold: assert property (p_tmr_hold)
        else $error("timer mode updated without overflow");

    property p_reset;
        @(posedge clk_sys_i) disable iff (1'b0)
        !resetn_i |=> ctrl0 == '0 && ctrl1 == '0 && high0 == 8'h00 && low1 == 8'h00;
    endproperty
    a_reset: assert property (p_reset)
        else $error("registers not cleared by reset");

    property p_latch;
        pop && !fifo_out.chan |=> conv0_o.word == $past(fifo_out.word);
    endproperty
    a_latch: assert property (p_latch)
        else $error("converter latch not loaded");

    property p_stall;
        req0 && !fifo_in_ready |=> req0 && word0 == $past(word0) || $past(wr_high0)
                                   || $past(ddu_pkg::ovf_sel(ctrl0.mode, tmr_ovf));
    endproperty
    a_stall: assert property (p_stall)
        else $error("pending word lost while queue full");

    c_write_mode: cover property (wr_low0 ##1 wr_high0 ##[1:20] pop);
    c_timer_mode: cover property (ctrl1.mode == ddu_pkg::MODE_T4 && tmr4_ovf_i ##1 req1);
    c_full:       cover property (req0 && !fifo_in_ready);
    c_both:       cover property (req0 && req1);

endmodule

`default_nettype wire

/* logic/ddu_pkg.sv */
// Package: constants, types and helpers for the dual converter update control
// ---------------------------------------------------------------------------
// Overview of operation
// - Enable bit clear: channel in low-power shutdown, output pin disabled.
// - Enable bit set: channel operational and its output pin driven.
// - Update mode 00: high data byte write moves held data to converter latch.
// - Update modes 01, 10, 11: timer 3, timer 4, timer 2 overflow triggers update.
// - Mode in bits 4:3, justification in bits 2:0; bits 6:5 read zero.
// - Justify 000: word is high byte bits 3:0 then whole low byte.
// - Justify 001: word is high byte bits 4:0 then low bits 7:1.
// - Justify 010: word is high byte bits 5:0 then low bits 7:2.
// - Justify 011: word is high byte bits 6:0 then low bits 7:3.
// - Justify 1xx: word is whole high byte then low bits 7:4.
// - First channel high data byte is read/write at 0xD3, page 0.
// - Control registers at 0xD4: page 0 first channel, page 1 second.
// - Write-triggered mode holds low byte writes until next high byte write.
// - Timer modes hold both data bytes until the selected timer overflows.
// ---------------------------------------------------------------------------
`default_nettype none

package ddu_pkg;

    // -----------------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA_LOW  = 8'hD2;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'hD3;
    localparam logic [7:0] ADDR_CTRL      = 8'hD4;
    localparam logic [7:0] PAGE_CH0       = 8'h00;
    localparam logic [7:0] PAGE_CH1       = 8'h01;
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] DATA_RST       = 8'h00;
    localparam logic [7:0] CTRL_WMASK     = 8'h9F;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // -----------------------------------------------------------------------
    // Field codes
    // -----------------------------------------------------------------------
    localparam logic [1:0] MODE_WRITE = 2'h0;
    localparam logic [1:0] MODE_T3    = 2'h1;
    localparam logic [1:0] MODE_T4    = 2'h2;
    localparam logic [1:0] MODE_T2    = 2'h3;
    localparam int         OVF_T2     = 0;
    localparam int         OVF_T3     = 1;
    localparam int         OVF_T4     = 2;
    localparam int         FIFO_DEPTH = 16;

    typedef struct packed {
        logic       enable;
        logic [1:0] rsv;
        logic [1:0] mode;
        logic [2:0] justify;
    } ddu_ctrl_type;

    typedef struct packed {
        logic        chan;
        logic [11:0] word;
    } ddu_upd_type;

    typedef struct packed {
        logic        drive;
        logic        shutdown;
        logic [11:0] word;
    } ddu_out_type;

    // Register decode on address and page
    function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] page,
                                     input logic [7:0] a, input logic [7:0] p);
        sfr_hit = (addr == a) && (page == p);
    endfunction

    // Overflow pulse of the timer that the mode selects
    function automatic logic ovf_sel(input logic [1:0] mode, input logic [2:0] ovf);
        case (mode)
            MODE_T3: ovf_sel = ovf[OVF_T3];
            MODE_T4: ovf_sel = ovf[OVF_T4];
            MODE_T2: ovf_sel = ovf[OVF_T2];
            default: ovf_sel = 1'b0;
        endcase
    endfunction

    // Twelve-bit word from the two data bytes
    function automatic logic [11:0] justify(input logic [2:0] code, input logic [7:0] hi,
                                            input logic [7:0] lo);
        case (code)
            3'h0:    justify = {hi[3:0], lo};
            3'h1:    justify = {hi[4:0], lo[7:1]};
            3'h2:    justify = {hi[5:0], lo[7:2]};
            3'h3:    justify = {hi[6:0], lo[7:3]};
            default: justify = {hi, lo[7:4]};
        endcase
    endfunction

endpackage

`default_nettype wire

/* logic/ddu_fifo.sv */
// Parameterised flip-flop FIFO with valid and ready on both sides
`default_nettype none

module ddu_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_i,   // System clock
    input  wire logic             resetn_i,    // Synchronous reset, active low
    input  wire logic             in_valid_i,  // Write side valid
    output logic                  in_ready_o,  // Not full
    input  wire logic [WIDTH-1:0] in_data_i,   // Write data
    output logic                  out_valid_o, // Not empty
    input  wire logic             out_ready_i, // Read side ready
    output logic      [WIDTH-1:0] out_data_o   // Head entry
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wptr_r;
    logic [AW:0]      rptr_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = !((wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
    assign out_valid_o = (wptr_r != rptr_r);
    assign out_data_o  = mem_r[rptr_r[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_r[wptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wptr_r <= '0;
        end else if (push) begin
            wptr_r <= wptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rptr_r <= '0;
        end else if (pop) begin
            rptr_r <= rptr_r + 1'b1;
        end
    end

endmodule

`default_nettype wire

/* logic/ddu_chan.sv */
// One converter channel: control and data registers and update trigger
`default_nettype none

module ddu_chan (
    input  wire logic               clk_sys_i, // System clock
    input  wire logic               resetn_i,  // Synchronous reset, active low
    input  wire logic               wr_low_i,  // Low data byte write strobe
    input  wire logic               wr_high_i, // High data byte write strobe
    input  wire logic               wr_ctrl_i, // Control write strobe
    input  wire logic [7:0]         wdata_i,   // Write data
    input  wire logic [2:0]         ovf_i,     // Timer overflow pulses
    input  wire logic               take_i,    // Pending word accepted
    output ddu_pkg::ddu_ctrl_type   ctrl_o,    // Control register
    output logic      [7:0]         low_o,     // Low data byte
    output logic      [7:0]         high_o,    // High data byte
    output logic                    req_o,     // Update word pending
    output logic      [11:0]        word_o     // Pending justified word
);
    logic [7:0] low_nxt;
    logic [7:0] high_nxt;
    logic       trig;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctrl_o <= ddu_pkg::ddu_ctrl_type'(ddu_pkg::CTRL_RST);
        end else if (wr_ctrl_i) begin
            ctrl_o <= ddu_pkg::ddu_ctrl_type'(wdata_i & ddu_pkg::CTRL_WMASK);
        end
    end

    // ------------------------------------------------------------------------
    // Data bytes are held here and do not reach the converter directly
    // ------------------------------------------------------------------------
    assign low_nxt  = wr_low_i ? wdata_i : low_o;
    assign high_nxt = wr_high_i ? wdata_i : high_o;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            low_o  <= ddu_pkg::DATA_RST;
            high_o <= ddu_pkg::DATA_RST;
        end else begin
            low_o  <= low_nxt;
            high_o <= high_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Trigger: high byte write or selected timer overflow
    // ------------------------------------------------------------------------
    assign trig = (ctrl_o.mode == ddu_pkg::MODE_WRITE) ? wr_high_i
                : ddu_pkg::ovf_sel(ctrl_o.mode, ovf_i);

    // A new trigger wins over an acceptance in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            req_o  <= 1'b0;
            word_o <= '0;
        end else if (trig) begin
            req_o  <= 1'b1;
            word_o <= ddu_pkg::justify(ctrl_o.justify, high_nxt, low_nxt);
        end else if (take_i) begin
            req_o  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* tb/ddu_cpu_model.sv */
// Processor model driving the register bus
`default_nettype none
module ddu_cpu_model (
    input  wire logic       clk_sys_i, // Clock
    output logic      [7:0] addr_o,    // Address
    output logic      [7:0] page_o,    // Page
    output logic            wr_o,      // Write strobe
    output logic      [7:0] wdata_o,   // Write data
    output logic            ready_o    // Latch accepts
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {addr_o, page_o, wr_o, wdata_o} = '0;
        ready_o = 1'b1;
    end
    task automatic wr(input logic [7:0] a, p, d);
        @(posedge clk_sys_i);
        addr_o <= a;
        page_o <= p;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
    endtask
    // Latch acceptance, changed on a clock edge
    task automatic hold(input logic r);
        @(posedge clk_sys_i);
        ready_o <= r;
    endtask
    // Present address; read data settles one edge on, task returns after two
    task automatic pt(input logic [7:0] a, p);
        @(posedge clk_sys_i);
        addr_o <= a;
        page_o <= p;
        repeat (2) @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

/* tb/ddu_top_test.sv */
// Self-checking bench for the dual converter update control
`default_nettype none
module ddu_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] LO = ddu_pkg::ADDR_DATA_LOW;
    localparam logic [7:0] HI = ddu_pkg::ADDR_DATA_HIGH;
    localparam logic [7:0] CT = ddu_pkg::ADDR_CTRL;
    logic                 clk_sys_i = 1'b0;
    logic                 resetn_i  = 1'b0;
    logic           [2:0] tmr       = 3'h0;
    logic           [7:0] addr, page, wdata, rdata;
    logic                 wr, rdy;
    ddu_pkg::ddu_out_type c0, c1;
    int                   fail_count  = 0;
    int                   checks_done = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    ddu_cpu_model cpu_u (.clk_sys_i(clk_sys_i), .addr_o(addr), .page_o(page), .wr_o(wr),
                         .wdata_o(wdata), .ready_o(rdy));
    ddu_top dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sfr_addr_i(addr),
                   .sfr_page_i(page), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
                   .tmr2_ovf_i(tmr[0]), .tmr3_ovf_i(tmr[1]), .tmr4_ovf_i(tmr[2]),
                   .conv_ready_i(rdy), .conv0_o(c0), .conv1_o(c1));
    task automatic chk(input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] o(input int ch);
        return ch ? c1.word : c0.word;
    endfunction
    task automatic settle;
        repeat (6) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic t_reset;
        cpu_u.pt(CT, 8'h01);
        #1;
        chk(rdata, 8'h00);
        chk({c0.drive, c0.shutdown, c1.drive, c1.shutdown}, 4'h5);
    endtask
    task automatic t_ctrl;
        cpu_u.wr(CT, 8'h00, 8'hFF);
        cpu_u.pt(CT, 8'h00);
        #1;
        chk(rdata, 8'h9F);
        chk({c0.drive, c0.shutdown, c1.drive}, 3'h4);
        cpu_u.pt(CT, 8'h01);
        #1;
        chk(rdata, 8'h00);
        cpu_u.wr(HI, 8'h00, 8'h3C);
        cpu_u.pt(HI, 8'h00);
        #1;
        chk(rdata, 8'h3C);
        cpu_u.pt(8'h10, 8'h00);
        #1;
        chk(rdata, 8'h00);
    endtask
    task automatic t_write;
        logic [15:0] v;
        logic [11:0] e;
        for (int ch = 0; ch < 2; ch++) for (int c = 0; c < 8; c++) begin
            v = {8'hC3 ^ 8'(c), 8'h5A + 8'(c)};
            e = 12'(v >> (c > 4 ? 4 : c));
            cpu_u.wr(CT, 8'(ch), 8'h80 | 8'(c));
            cpu_u.wr(LO, 8'(ch), v[7:0]);
            cpu_u.wr(HI, 8'(ch), v[15:8]);
            settle;
            chk(o(ch), e);
            cpu_u.wr(LO, 8'(ch), ~v[7:0]);
            settle;
            chk(o(ch), e);
        end
    endtask
    task automatic pulse(input logic [2:0] s);
        @(posedge clk_sys_i);
        tmr <= s;
        @(posedge clk_sys_i);
        tmr <= 3'h0;
    endtask
    task automatic t_timer;
        logic [2:0] sel;
        cpu_u.wr(CT, 8'h00, 8'h80);
        cpu_u.wr(LO, 8'h00, 8'h00);
        cpu_u.wr(HI, 8'h00, 8'h00);
        for (int m = 1; m < 4; m++) begin
            sel = (m == 1) ? 3'h2 : (m == 2) ? 3'h4 : 3'h1;
            cpu_u.wr(CT, 8'h00, 8'h80 | 8'(m << 3));
            cpu_u.wr(LO, 8'h00, 8'h20 + 8'(m));
            cpu_u.wr(HI, 8'h00, 8'(m));
            settle;
            chk(o(0), 12'(m - 1) << 8 | (m > 1 ? 12'h20 + 12'(m - 1) : 12'h0));
            pulse(~sel);
            settle;
            chk(o(0), 12'(m - 1) << 8 | (m > 1 ? 12'h20 + 12'(m - 1) : 12'h0));
            pulse(sel);
            settle;
            chk(o(0), 12'(m) << 8 | 12'h20 + 12'(m));
        end
    endtask
    task automatic t_stall;
        cpu_u.hold(1'b0);
        cpu_u.wr(LO, 8'h00, 8'h77);
        cpu_u.wr(HI, 8'h00, 8'h05);
        repeat (17) pulse(3'h1);
        settle;
        chk(c0.word, 12'h323);
        cpu_u.hold(1'b1);
        repeat (4) settle;
        chk(c0.word, 12'h577);
        chk({c0.drive, c1.drive}, 2'h3);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        t_reset;
        t_ctrl;
        t_write;
        t_timer;
        t_stall;
        wrap_up;
    end
    initial begin
        #200000;
        fail_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
